/* File: rtl/sge_pkg.sv */
// Purpose: Shared constants and types for the serial-bus sixteen-bit GPIO expander.
// Assumes: One 100 MHz system clock; the serial bus is sampled, never used as a clock.
// Notes:   Register pairs are selected by pointer bits [2:1], the port by bit [0].
package sge_pkg;

    // Fixed upper four bits of the slave address.
    localparam logic [3:0]  SGE_ADDR_PREFIX = 4'h4;
    // Bit count that marks a complete byte.
    localparam logic [3:0]  SGE_BYTE_BITS   = 4'h8;
    localparam logic [3:0]  SGE_LAST_BIT    = 4'h7;

    // Register pair codes, pointer bits [2:1].
    localparam logic [1:0]  SGE_PAIR_IN     = 2'h0;
    localparam logic [1:0]  SGE_PAIR_OUT    = 2'h1;
    localparam logic [1:0]  SGE_PAIR_POL    = 2'h2;
    localparam logic [1:0]  SGE_PAIR_DIR    = 2'h3;

    // Register reset values.
    localparam logic [15:0] SGE_OUT_RST     = 16'hffff;
    localparam logic [15:0] SGE_POL_RST     = 16'h0000;
    localparam logic [15:0] SGE_DIR_RST     = 16'hffff;
    localparam logic [2:0]  SGE_PTR_RST     = 3'h0;

    // Cycles after reset release during which the input snapshot follows the pins.
    localparam logic [1:0]  SGE_INIT_DONE   = 2'h3;
    // Buffer depth.
    localparam logic [1:0]  SGE_BUF_DEPTH   = 2'h2;

    typedef enum logic [6:0] {
        SGE_ST_IDLE = 7'b0000001,
        SGE_ST_RX   = 7'b0000010,
        SGE_ST_ACK  = 7'b0000100,
        SGE_ST_TX   = 7'b0001000,
        SGE_ST_MACK = 7'b0010000,
        SGE_ST_WAIT = 7'b0100000,
        SGE_ST_SPARE = 7'b1000000
    } sge_state_e_t;

    typedef enum logic [1:0] {
        SGE_PH_ADDR = 2'h0,
        SGE_PH_CMD  = 2'h1,
        SGE_PH_DATA = 2'h2
    } sge_phase_t;

    typedef struct packed {
        logic [2:0] ptr;
        logic [7:0] data;
    } sge_entry_t;

    typedef struct packed {
        logic            scl_s1;
        logic            scl_s2;
        logic            scl_s3;
        logic            sda_s1;
        logic            sda_s2;
        logic            sda_s3;
        logic [2:0]      strap_s1;
        logic [2:0]      strap_s2;
        logic [15:0]     pin_s1;
        logic [15:0]     pin_s2;
        sge_state_e_t    st;
        sge_phase_t      ph;
        logic [3:0]      cnt;
        logic [7:0]      shreg;
        logic            rw;
        logic            mack;
        logic [2:0]      ptr;
        logic [15:0]     outr;
        logic [15:0]     pol;
        logic [15:0]     dir;
        logic [15:0]     snap;
        logic [1:0]      init;
        logic            sda_oe;
        logic            int_oe;
        sge_entry_t [1:0] fifo;
        logic            wptr;
        logic            rptr;
        logic [1:0]      fcnt;
    } sge_regs_t;

endpackage : sge_pkg

/* File: rtl/sge_expander.sv */
// Purpose: Serial-bus slave GPIO expander with sixteen pins and a change alert.
// Assumes: SCL and SDA are slow against clk_sys and pass two flip-flops first.
// Notes:   Written bytes pass a two-entry buffer; wr_hold stalls its drain.
`timescale 1ns/1ps

module sge_expander
    import sge_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Serial bus; SDA is open drain.
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // Address straps.
    input  wire logic       strap_sel_bit0,
    input  wire logic       strap_sel_bit1,
    input  wire logic       strap_sel_bit2,
    // Port pins.
    input  wire logic [7:0] port_lo_pins_in,
    output logic      [7:0] port_lo_pins_out,
    output logic      [7:0] port_lo_pins_oe,
    input  wire logic [7:0] port_hi_pins_in,
    output logic      [7:0] port_hi_pins_out,
    output logic      [7:0] port_hi_pins_oe,
    // Change alert, open drain, active low.
    output logic            alert_n_out,
    output logic            alert_n_oe,
    // Control and status.
    input  wire logic       wr_hold,
    output logic            buf_ready
);
    import sge_pkg::*;

    sge_regs_t  q;
    sge_regs_t  next_q;

    logic        scl_rise;
    logic        scl_fall;
    logic        start_ev;
    logic        stop_ev;
    logic        addr_match;
    logic        alert_lo;
    logic        alert_hi;
    logic [15:0] in_val;
    logic [7:0]  tx_byte;
    logic        push;
    logic        pop;
    logic        load_lo;
    logic        load_hi;
    sge_entry_t  head;

    localparam sge_regs_t SGE_RESET = '{
        st: SGE_ST_IDLE, ph: SGE_PH_ADDR, ptr: SGE_PTR_RST,
        outr: SGE_OUT_RST, pol: SGE_POL_RST, dir: SGE_DIR_RST,
        default: '0
    };

    assign scl_rise   = q.scl_s2 & ~q.scl_s3;
    assign scl_fall   = ~q.scl_s2 & q.scl_s3;
    assign start_ev   = q.scl_s2 & q.scl_s3 & q.sda_s3 & ~q.sda_s2;
    assign stop_ev    = q.scl_s2 & q.scl_s3 & ~q.sda_s3 & q.sda_s2;
    assign addr_match = (q.shreg[7:4] == SGE_ADDR_PREFIX)
                      && (q.shreg[3:1] == q.strap_s2);

    // Input read data shows the pin level inverted by the polarity register, whatever the direction.
    assign in_val  = q.pin_s2 ^ q.pol;
    always_comb begin
        case (q.ptr[2:1])
            SGE_PAIR_IN:  tx_byte = q.ptr[0] ? in_val[15:8] : in_val[7:0];
            SGE_PAIR_OUT: tx_byte = q.ptr[0] ? q.outr[15:8] : q.outr[7:0];
            SGE_PAIR_POL: tx_byte = q.ptr[0] ? q.pol[15:8] : q.pol[7:0];
            default:      tx_byte = q.ptr[0] ? q.dir[15:8] : q.dir[7:0];
        endcase
    end

    // Per-port alert sources compare live input pins with the last read snapshot.
    assign alert_lo = (q.init == SGE_INIT_DONE)
                    && |((q.pin_s2[7:0] ^ q.snap[7:0]) & q.dir[7:0]);
    assign alert_hi = (q.init == SGE_INIT_DONE)
                    && |((q.pin_s2[15:8] ^ q.snap[15:8]) & q.dir[15:8]);

    assign buf_ready = (q.fcnt != SGE_BUF_DEPTH);
    assign head      = q.fifo[q.rptr];
    assign pop       = (q.fcnt != 2'h0) && !wr_hold;
    assign push      = (q.st == SGE_ST_RX) && (q.ph == SGE_PH_DATA) && !q.rw && scl_fall
                    && (q.cnt == SGE_BYTE_BITS) && buf_ready && !start_ev && !stop_ev;

    // A byte goes out whenever a read starts or the master acknowledged the last one.
    logic load_tx;
    assign load_tx = scl_fall && !start_ev && !stop_ev
                  && (((q.st == SGE_ST_ACK) && (q.ph == SGE_PH_ADDR) && q.rw)
                   || ((q.st == SGE_ST_MACK) && q.mack));
    assign load_lo = load_tx && (q.ptr == 3'h0);
    assign load_hi = load_tx && (q.ptr == 3'h1);

    always_comb begin
        next_q = q;
        next_q.scl_s1   = scl_in;
        next_q.scl_s2   = q.scl_s1;
        next_q.scl_s3   = q.scl_s2;
        next_q.sda_s1   = sda_in;
        next_q.sda_s2   = q.sda_s1;
        next_q.sda_s3   = q.sda_s2;
        next_q.strap_s1 = {strap_sel_bit2, strap_sel_bit1, strap_sel_bit0};
        next_q.strap_s2 = q.strap_s1;
        next_q.pin_s1   = {port_hi_pins_in, port_lo_pins_in};
        next_q.pin_s2   = q.pin_s1;

        // The snapshot follows the pins until the synchronisers have filled.
        if (q.init != SGE_INIT_DONE) begin
            next_q.init = q.init + 2'h1;
            next_q.snap = q.pin_s2;
        end
        if (load_lo) begin
            next_q.snap[7:0] = q.pin_s2[7:0];
        end
        if (load_hi) begin
            next_q.snap[15:8] = q.pin_s2[15:8];
        end
        next_q.int_oe = alert_lo | alert_hi;

        if (start_ev) begin
            next_q.st     = SGE_ST_RX;
            next_q.ph     = SGE_PH_ADDR;
            next_q.cnt    = 4'h0;
            next_q.sda_oe = 1'b0;
        end else if (stop_ev) begin
            next_q.st     = SGE_ST_IDLE;
            next_q.sda_oe = 1'b0;
        end else begin
            case (q.st)
                SGE_ST_RX: begin
                    if (scl_rise && (q.cnt != SGE_BYTE_BITS)) begin
                        next_q.shreg = {q.shreg[6:0], q.sda_s2};
                        next_q.cnt   = q.cnt + 4'h1;
                    end else if (scl_fall && (q.cnt == SGE_BYTE_BITS)) begin
                        case (q.ph)
                            SGE_PH_ADDR: begin
                                if (addr_match) begin
                                    next_q.rw     = q.shreg[0];
                                    next_q.st     = SGE_ST_ACK;
                                    next_q.sda_oe = 1'b1;
                                end else begin
                                    next_q.st = SGE_ST_IDLE;
                                end
                            end
                            SGE_PH_CMD: begin
                                next_q.ptr    = q.shreg[2:0];
                                next_q.st     = SGE_ST_ACK;
                                next_q.sda_oe = 1'b1;
                            end
                            default: begin
                                if (buf_ready) begin
                                    next_q.ptr    = {q.ptr[2:1], ~q.ptr[0]};
                                    next_q.st     = SGE_ST_ACK;
                                    next_q.sda_oe = 1'b1;
                                end else begin
                                    next_q.st = SGE_ST_WAIT;
                                end
                            end
                        endcase
                    end
                end
                SGE_ST_ACK: begin
                    if (scl_fall) begin
                        next_q.sda_oe = 1'b0;
                        next_q.cnt    = 4'h0;
                        if (!((q.ph == SGE_PH_ADDR) && q.rw)) begin
                            next_q.st = SGE_ST_RX;
                            next_q.ph = (q.ph == SGE_PH_ADDR) ? SGE_PH_CMD : SGE_PH_DATA;
                        end
                    end
                end
                SGE_ST_TX: begin
                    if (scl_fall) begin
                        if (q.cnt == SGE_LAST_BIT) begin
                            next_q.sda_oe = 1'b0;
                            next_q.st     = SGE_ST_MACK;
                        end else begin
                            next_q.cnt    = q.cnt + 4'h1;
                            next_q.shreg  = {q.shreg[6:0], 1'b0};
                            next_q.sda_oe = ~q.shreg[6];
                        end
                    end
                end
                SGE_ST_MACK: begin
                    if (scl_rise) begin
                        next_q.mack = ~q.sda_s2;
                    end else if (scl_fall && !q.mack) begin
                        next_q.st = SGE_ST_WAIT;
                    end
                end
                SGE_ST_IDLE,
                SGE_ST_WAIT: begin
                    next_q.sda_oe = 1'b0;
                end
                default: begin
                    next_q.st     = SGE_ST_IDLE;
                    next_q.sda_oe = 1'b0;
                end
            endcase
            if (load_tx) begin
                next_q.st     = SGE_ST_TX;
                next_q.shreg  = tx_byte;
                next_q.cnt    = 4'h0;
                next_q.sda_oe = ~tx_byte[7];
                next_q.ptr    = {q.ptr[2:1], ~q.ptr[0]};
            end
        end

        // Written bytes carry their target pointer through the buffer.
        if (push) begin
            next_q.fifo[q.wptr] = '{ptr: q.ptr, data: q.shreg};
            next_q.wptr         = ~q.wptr;
        end
        if (pop) begin
            next_q.rptr = ~q.rptr;
            case (head.ptr[2:1])
                SGE_PAIR_OUT: begin
                    if (head.ptr[0]) next_q.outr[15:8] = head.data;
                    else             next_q.outr[7:0]  = head.data;
                end
                SGE_PAIR_POL: begin
                    if (head.ptr[0]) next_q.pol[15:8] = head.data;
                    else             next_q.pol[7:0]  = head.data;
                end
                SGE_PAIR_DIR: begin
                    if (head.ptr[0]) next_q.dir[15:8] = head.data;
                    else             next_q.dir[7:0]  = head.data;
                end
                default: begin
                    next_q.rptr = ~q.rptr;
                end
            endcase
        end
        next_q.fcnt = q.fcnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q <= SGE_RESET;
        end else begin
            q <= next_q;
        end
    end

    assign sda_out          = 1'b0;
    assign sda_oe           = q.sda_oe;
    assign alert_n_out      = 1'b0;
    assign alert_n_oe       = q.int_oe;
    assign port_lo_pins_out = q.outr[7:0];
    assign port_hi_pins_out = q.outr[15:8];
    assign port_lo_pins_oe  = ~q.dir[7:0];
    assign port_hi_pins_oe  = ~q.dir[15:8];

    default clocking sge_cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    alert_set_a: assert property ((alert_lo || alert_hi) |=> q.int_oe)
        else $error("alert not raised for a changed input");
    alert_release_a: assert property (!(alert_lo || alert_hi) |=> !alert_n_oe)
        else $error("alert held with no cause");
    port_split_a: assert property (load_lo |=> $stable(q.snap[15:8]))
        else $error("port 0 read disturbed port 1 snapshot");
    turn_input_a: assert property ($rose(q.dir[0]) && (q.pin_s2[0] != q.snap[0])
        && (q.init == SGE_INIT_DONE) && $stable(q.pin_s2[0]) |=> alert_n_oe)
        else $error("no alert after output turned to input");
    idle_hold_a: assert property ((q.st == SGE_ST_IDLE) && !start_ev
        |=> (q.st == SGE_ST_IDLE) && !sda_oe)
        else $error("device left idle without a start");
    stop_idle_a: assert property (stop_ev |=> (q.st == SGE_ST_IDLE) && !sda_oe)
        else $error("stop did not return to idle");
    sda_low_only_a: assert property ($changed(sda_oe) |-> !q.scl_s3)
        else $error("sda driven change while scl high");
    addr_miss_a: assert property ((q.st == SGE_ST_RX) && (q.ph == SGE_PH_ADDR)
        && scl_fall && (q.cnt == SGE_BYTE_BITS) && !addr_match && !start_ev && !stop_ev
        |=> (q.st == SGE_ST_IDLE) && !sda_oe)
        else $error("foreign address acknowledged");
    addr_ack_a: assert property ((q.st == SGE_ST_RX) && (q.ph == SGE_PH_ADDR)
        && scl_fall && (q.cnt == SGE_BYTE_BITS) && addr_match && !start_ev && !stop_ev
        |=> sda_oe && (q.st == SGE_ST_ACK))
        else $error("matching address not acknowledged");
    data_ack_a: assert property (push |=> sda_oe ##1 (sda_oe || scl_fall))
        else $error("written byte not acknowledged");
    nack_wait_a: assert property ((q.st == SGE_ST_MACK) && scl_fall && !q.mack
        && !start_ev && !stop_ev |=> (q.st == SGE_ST_WAIT) && !sda_oe)
        else $error("device kept sending after master nack");
    ptr_toggle_a: assert property (push
        |=> q.ptr == {$past(q.ptr[2:1]), ~$past(q.ptr[0])})
        else $error("pointer did not toggle within its pair");
    in_readonly_a: assert property (pop && (head.ptr[2:1] == SGE_PAIR_IN)
        |=> $stable(q.outr) && $stable(q.pol) && $stable(q.dir))
        else $error("write to input register changed state");

    // The acknowledge drive may only move on a clock fall, and a sent byte ends released.
    ack_hold_a: assert property ((q.st == SGE_ST_ACK) && !scl_fall
        && !start_ev && !stop_ev |=> sda_oe == $past(sda_oe))
        else $error("acknowledge drive moved while clock high");
    tx_release_a: assert property ((q.st == SGE_ST_TX) && scl_fall
        && (q.cnt == SGE_LAST_BIT) && !start_ev && !stop_ev
        |=> !sda_oe && (q.st == SGE_ST_MACK))
        else $error("data line not released after eighth bit");

    // Main scenarios: read start, write, full buffer, master ack and nack.
    read_start_c: cover property (load_tx && (q.st == SGE_ST_ACK));
    read_more_c:  cover property ((q.st == SGE_ST_MACK) && scl_fall && q.mack);
    write_data_c: cover property (push);
    buf_full_c:   cover property (!buf_ready ##1 push == 1'b0);
    master_nack_c: cover property ((q.st == SGE_ST_MACK) && scl_fall && !q.mack);

endmodule : sge_expander

/* File: verif/sge_bus_master.sv */
// Purpose: Behavioural serial-bus master that clocks SCL and works SDA as open drain.
// Assumes: SCL phases of four clk_sys cycles, an 80 ns bus period.
// Notes:   Tasks are called from the bench; sda_low high pulls the wire down.
`timescale 1ns/1ps
module sge_bus_master (
    // Clock and resolved wire.
    input  wire logic       clk_sys,
    input  wire logic       sda_wire,
    // Bus lines driven by the master.
    output logic            scl,
    output logic            sda_low,
    // Byte taken in a read, with a one-cycle strobe.
    output logic [7:0]      rd_byte,
    output logic            rd_stb
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        rd_byte = 8'h00;
        rd_stb = 1'b0;
    end

    task automatic half();
        repeat (4) @(posedge clk_sys);
        #1;
    endtask : half

    // One clock pulse; data moves one cycle after SCL fell.
    task automatic xfer(input logic b, output logic r);
        @(posedge clk_sys);
        #1 sda_low = !b;
        repeat (3) @(posedge clk_sys);
        #1 scl = 1'b1;
        half();
        r = sda_wire;
        scl = 1'b0;
    endtask : xfer

    task automatic start();
        @(posedge clk_sys);
        #1 sda_low = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b1;
        half();
        scl = 1'b0;
    endtask : start

    task automatic stop();
        @(posedge clk_sys);
        #1 sda_low = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b0;
        half();
    endtask : stop

    // Eight bits MSB first, then the slave's acknowledge slot.
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xfer(d[i], r);
        xfer(1'b1, r);
        ack = !r;
    endtask : wbyte

    // A missing acknowledge ends the read.
    task automatic rbyte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
        xfer(!ack, r);
        rd_byte = d;
        rd_stb = 1'b1;
        @(posedge clk_sys);
        #1 rd_stb = 1'b0;
    endtask : rbyte
endmodule : sge_bus_master

/* File: verif/sge_expander_bench.sv */
// Purpose: Self-checking bench for the serial-bus GPIO expander.
// Assumes: Straps tied to 3'h5; bus master model at an 80 ns SCL period.
// Notes:   Read bytes are compared against a queue filled by the driver.
`timescale 1ns/1ps
module sge_expander_bench;
    import sge_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        wr_hold = 1'b0;
    logic [2:0]  strap = 3'h5;
    logic [7:0]  ext_lo = 8'h3c;
    logic [7:0]  ext_hi = 8'ha5;
    logic [15:0] seed = 16'h0050;
    logic [7:0]  q[$];
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          cyc = 0;
    logic        ack;
    logic        scl, sda_low, sda_oe, sda_out, rd_stb, alert_n_out, alert_n_oe, buf_ready;
    logic [7:0]  lo_out, lo_oe, hi_out, hi_oe, lo_in, hi_in, rd_byte;
    wire         sda_wire = !(sda_low || (sda_oe && !sda_out));

    // Pins show the driven value when enabled, the outside level otherwise.
    assign lo_in = (lo_oe & lo_out) | (~lo_oe & ext_lo);
    assign hi_in = (hi_oe & hi_out) | (~hi_oe & ext_hi);

    sge_expander uut (.clk_sys(clk_sys), .rst(rst), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe(sda_oe), .strap_sel_bit0(strap[0]),
        .strap_sel_bit1(strap[1]), .strap_sel_bit2(strap[2]), .port_lo_pins_in(lo_in),
        .port_lo_pins_out(lo_out), .port_lo_pins_oe(lo_oe), .port_hi_pins_in(hi_in),
        .port_hi_pins_out(hi_out), .port_hi_pins_oe(hi_oe), .alert_n_out(alert_n_out),
        .alert_n_oe(alert_n_oe), .wr_hold(wr_hold), .buf_ready(buf_ready));
    sge_bus_master m (.clk_sys(clk_sys), .sda_wire(sda_wire), .scl(scl),
        .sda_low(sda_low), .rd_byte(rd_byte), .rd_stb(rd_stb));

    always #5 clk_sys = ~clk_sys;

    function automatic logic [15:0] xs();
        seed = seed ^ (seed << 7);
        seed = seed ^ (seed >> 9);
        seed = seed ^ (seed << 8);
        return seed;
    endfunction : xs

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
        chk({8'h00, got}, {8'h00, exp});
    endtask : chk_rd

    task automatic stop_test();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic wr(input logic [7:0] c, input logic [7:0] d0, input logic [7:0] d1);
        logic [7:0] b[4];
        b = '{{SGE_ADDR_PREFIX, strap, 1'b0}, c, d0, d1};
        m.start();
        foreach (b[i]) begin
            m.wbyte(b[i], ack);
            chk(16'(ack), 16'h0001);
        end
        m.stop();
    endtask : wr

    // A read, with or without a fresh command byte, of one or two bytes.
    task automatic rd(input logic nc, input logic [7:0] c, input int n,
                      input logic [7:0] e0, input logic [7:0] e1);
        logic [7:0] d;
        if (!nc) begin
            m.start();
            m.wbyte({SGE_ADDR_PREFIX, strap, 1'b0}, ack);
            m.wbyte(c, ack);
        end
        m.start();
        m.wbyte({SGE_ADDR_PREFIX, strap, 1'b1}, ack);
        chk(16'(ack), 16'h0001);
        q.push_back(e0);
        if (n > 1) q.push_back(e1);
        m.rbyte(n > 1, d);
        if (n > 1) m.rbyte(1'b0, d);
        m.stop();
    endtask : rd

    always @(posedge clk_sys) begin
        if (rd_stb) chk_rd(rd_byte, q.pop_front());
    end

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 40000) begin
            n_mismatch++;
            stop_test();
        end
    end

    initial begin
        logic [15:0] r;
        logic [7:0]  bad[3] = '{8'h5a, 8'h48, 8'h4e};
        repeat (20) @(posedge clk_sys);
        #1 rst = 1'b0;
        repeat (8) @(posedge clk_sys);
        chk({hi_out, lo_out}, 16'hffff);
        chk({hi_oe, lo_oe}, 16'h0000);
        chk({14'h0, alert_n_oe, buf_ready}, 16'h0001);
        chk({14'h0, sda_out, alert_n_out}, 16'h0000);
        r = xs();
        wr(8'h02, r[7:0], r[15:8]);
        chk({hi_out, lo_out}, r);
        chk({hi_oe, lo_oe}, 16'h0000);
        wr(8'h06, 8'h00, 8'hff);
        chk({hi_oe, lo_oe}, 16'h00ff);
        rd(1'b0, 8'h02, 2, r[7:0], r[15:8]);
        rd(1'b0, 8'h00, 2, r[7:0], ext_hi);
        rd(1'b1, 8'h00, 1, r[7:0], 8'h00);
        wr(8'h00, 8'h12, 8'h34);
        chk({hi_out, lo_out}, r);
        wr(8'h04, 8'h0f, 8'hf0);
        rd(1'b0, 8'h00, 2, r[7:0] ^ 8'h0f, ext_hi ^ 8'hf0);
        wr(8'h04, 8'h00, 8'h00);
        foreach (bad[i]) begin
            m.start();
            m.wbyte(bad[i], ack);
            chk(16'(ack), 16'h0000);
            m.stop();
        end
        ext_hi = ext_hi ^ 8'h01;
        repeat (8) @(posedge clk_sys);
        chk(16'(alert_n_oe), 16'h0001);
        rd(1'b0, 8'h00, 1, r[7:0], 8'h00);
        chk(16'(alert_n_oe), 16'h0001);
        rd(1'b0, 8'h01, 1, ext_hi, 8'h00);
        chk(16'(alert_n_oe), 16'h0000);
        ext_lo = ~r[7:0];
        wr(8'h06, 8'hff, 8'hff);
        repeat (8) @(posedge clk_sys);
        chk(16'(alert_n_oe), 16'h0001);
        ext_lo = r[7:0];
        repeat (8) @(posedge clk_sys);
        chk(16'(alert_n_oe), 16'h0000);
        // Stall the drain so the buffer fills and refuses a third byte.
        wr_hold = 1'b1;
        m.start();
        m.wbyte({SGE_ADDR_PREFIX, strap, 1'b0}, ack);
        m.wbyte(8'h02, ack);
        m.wbyte(8'hc3, ack);
        m.wbyte(8'h3c, ack);
        chk(16'(buf_ready), 16'h0000);
        m.wbyte(8'h99, ack);
        chk(16'(ack), 16'h0000);
        m.stop();
        wr_hold = 1'b0;
        repeat (4) @(posedge clk_sys);
        chk({hi_out, lo_out}, 16'h3cc3);
        chk(16'(q.size()), 16'h0000);
        stop_test();
    end
endmodule : sge_expander_bench
